/* core/prs_supervisor.sv */
// Implementation choice: the APB slave port.
`timescale 1ns/1ns
`default_nettype none

module prs_supervisor
    import prs_pkg::*;
#(
    parameter int POR_CYC  = POR_CYC_DEFAULT,
    parameter int WD_EXP_0 = 17,
    parameter int WD_EXP_1 = 20,
    parameter int WD_EXP_2 = 23,
    parameter int WD_EXP_3 = 26
)(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              srst,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Supply monitor, oscillator detector, reset pin
    input  wire prs_supply_t       supply,
    input  wire logic              reset_in,
    // Reset and interrupt outputs
    output logic                   cpu_reset,
    output logic                   reset_out_n,
    output logic                   osc_run,
    output logic [15:0]            start_addr,
    output logic                   power_warning_irq,
    output logic [15:0]            power_warning_vector,
    output logic                   irq,
    // Protected configuration
    output prs_prot_cfg_t          prot_cfg
);

    localparam int WD_W  = 27;
    localparam int RC_W  = 17;

    // Byte address of a register index
    function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
        byte_addr = {2'b00, idx, 2'b00};
    endfunction

    // Watchdog period in clocks
    function automatic logic [WD_W-1:0] wd_len(input logic [1:0] sel);
        case (sel)
            2'd0:    wd_len = WD_W'(1) << WD_EXP_0;
            2'd1:    wd_len = WD_W'(1) << WD_EXP_1;
            2'd2:    wd_len = WD_W'(1) << WD_EXP_2;
            default: wd_len = WD_W'(1) << WD_EXP_3;
        endcase
    endfunction

    prs_ul_t            ul_state_r;
    logic [3:0]         ul_cnt_r;
    prs_seq_t           seq_r;
    logic [RC_W-1:0]    rst_cnt_r;
    logic [WD_W-1:0]    wd_cnt_r;
    logic [7:0]         watchdog_control_r;
    logic [1:0]         misc_r;
    logic [1:0]         wd_sel_r;
    logic [IRQ_W-1:0]   irq_stat_r;
    logic [IRQ_W-1:0]   irq_mask_r;
    logic               reset_in_q_r;
    logic [31:0]        rdata_nxt;
    logic               addr_ok;
    logic               wr;
    logic               prot_wr;
    logic               wd_hit;
    logic               osc_evt;
    logic               ext_rise;
    logic               wd_rst_evt;
    prs_seq_t           seq_nxt;

    // APB decode
    always_comb
    begin
        addr_ok   = 1'b1;
        rdata_nxt = 32'h0000_0000;
        if (paddr == byte_addr(UNLOCK_IDX))
        begin
            rdata_nxt = 32'h0000_0000;
        end
        else if (paddr == byte_addr(WATCHDOG_CONTROL_IDX))
        begin
            rdata_nxt = {24'h00_0000, watchdog_control_r};
        end
        else if (paddr == byte_addr(PROT_IDX))
        begin
            rdata_nxt = {18'h0_0000, prot_cfg};
        end
        else if (paddr == byte_addr(MISC_IDX))
        begin
            rdata_nxt = {26'h000_0000, wd_sel_r, 2'b00, misc_r};
        end
        else if (paddr == byte_addr(IRQ_STAT_IDX))
        begin
            rdata_nxt = {29'h0000_0000, irq_stat_r};
        end
        else if (paddr == byte_addr(IRQ_MASK_IDX))
        begin
            rdata_nxt = {29'h0000_0000, irq_mask_r};
        end
        else
        begin
            addr_ok = 1'b0;
        end
    end

    // Zero wait: pready is set in setup, so every transfer lasts two cycles, setup plus one access cycle
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~addr_ok;
            prdata  <= (psel & ~penable & ~pwrite) ? rdata_nxt : 32'h0000_0000;
        end
    end

    assign wr = psel & penable & pready & pwrite & addr_ok;
    assign prot_wr = wr & (ul_state_r == UL_OPEN) &
                     ((paddr == byte_addr(WATCHDOG_CONTROL_IDX)) || (paddr == byte_addr(PROT_IDX)) ||
                      (paddr == byte_addr(MISC_IDX)));

    // Unlock sequencer; any mapped-register write in between, other than a new first key, breaks the pair
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ul_state_r <= UL_IDLE;
            ul_cnt_r   <= 4'h0;
        end
        else if (wr)
        begin
            if (paddr == byte_addr(UNLOCK_IDX) && pwdata[7:0] == UNLOCK_KEY1)
            begin
                ul_state_r <= UL_GOT1;
            end
            else if (paddr == byte_addr(UNLOCK_IDX) && pwdata[7:0] == UNLOCK_KEY2 &&
                     ul_state_r == UL_GOT1)
            begin
                ul_state_r <= UL_OPEN;
                ul_cnt_r   <= 4'(UNLOCK_WIN_CYC - 1);
            end
            else
            begin
                ul_state_r <= UL_IDLE;
            end
        end
        else if (ul_state_r == UL_OPEN)
        begin
            if (ul_cnt_r == 4'h0)
            begin
                ul_state_r <= UL_IDLE;
            end
            else
            begin
                ul_cnt_r <= ul_cnt_r - 4'h1;
            end
        end
    end

    // Protected configuration bits
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            prot_cfg <= '0;
        end
        else if (prot_wr && paddr == byte_addr(PROT_IDX))
        begin
            prot_cfg <= prs_prot_cfg_t'(pwdata[13:0]);
        end
    end

    // Watchdog
    assign wd_hit = (seq_r == SEQ_RUN) && (wd_cnt_r >= wd_len(wd_sel_r) - WD_W'(1));
    assign wd_rst_evt = wd_hit & watchdog_control_r[WDC_EWT];

    always_ff @(posedge clk)
    begin
        if (srst || seq_r != SEQ_RUN)
        begin
            wd_cnt_r <= '0;
        end
        else if (prot_wr && paddr == byte_addr(WATCHDOG_CONTROL_IDX) && pwdata[WDC_RWT])
        begin
            wd_cnt_r <= '0;
        end
        else if (wd_hit)
        begin
            wd_cnt_r <= '0;
        end
        else
        begin
            wd_cnt_r <= wd_cnt_r + WD_W'(1);
        end
    end

    // Misc: oscillator detect, period select
    assign osc_evt = supply.osc_failed & misc_r[MISC_OSCILLATOR_FAIL_DETECT_ENABLE] & (seq_r != SEQ_OFF);

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            misc_r   <= 2'b00;
            wd_sel_r <= 2'b00;
        end
        else
        begin
            if (wr && paddr == byte_addr(MISC_IDX))
            begin
                wd_sel_r <= pwdata[MISC_WDSEL_HI:MISC_WDSEL_LO];
            end
            if (prot_wr && paddr == byte_addr(MISC_IDX))
            begin
                misc_r[MISC_OSCILLATOR_FAIL_DETECT_ENABLE] <= pwdata[MISC_OSCILLATOR_FAIL_DETECT_ENABLE];
            end
            // Hardware set wins over a software clear
            if (osc_evt)
            begin
                misc_r[MISC_OSCILLATOR_FAIL_FLAG] <= 1'b1;
            end
            else if (seq_r == SEQ_OFF)
            begin
                misc_r[MISC_OSCILLATOR_FAIL_FLAG] <= 1'b0;
            end
            else if (wr && paddr == byte_addr(MISC_IDX) && !pwdata[MISC_OSCILLATOR_FAIL_FLAG])
            begin
                misc_r[MISC_OSCILLATOR_FAIL_FLAG] <= 1'b0;
            end
        end
    end

    // Watchdog control
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            watchdog_control_r <= WATCHDOG_CONTROL_RST;
        end
        else
        begin
            if (wr && paddr == byte_addr(WATCHDOG_CONTROL_IDX))
            begin
                watchdog_control_r[WDC_POWER_WARNING_IRQ_ENABLE] <= pwdata[WDC_POWER_WARNING_IRQ_ENABLE];
            end
            if (supply.below_warning)
            begin
                watchdog_control_r[WDC_PFI] <= 1'b1;
            end
            else if (wr && paddr == byte_addr(WATCHDOG_CONTROL_IDX) && !pwdata[WDC_PFI])
            begin
                watchdog_control_r[WDC_PFI] <= 1'b0;
            end
            if (seq_r == SEQ_OFF && supply.above_reset)
            begin
                watchdog_control_r[WDC_POR] <= 1'b1;
            end
            else if (prot_wr && paddr == byte_addr(WATCHDOG_CONTROL_IDX))
            begin
                watchdog_control_r[WDC_POR] <= pwdata[WDC_POR];
            end
            if (wd_hit)
            begin
                watchdog_control_r[WDC_WATCHDOG_IRQ_FLAG] <= 1'b1;
            end
            else if (prot_wr && paddr == byte_addr(WATCHDOG_CONTROL_IDX))
            begin
                watchdog_control_r[WDC_WATCHDOG_IRQ_FLAG] <= pwdata[WDC_WATCHDOG_IRQ_FLAG];
            end
            if (wd_rst_evt)
            begin
                watchdog_control_r[WDC_WTRF] <= 1'b1;
            end
            else if (wr && paddr == byte_addr(WATCHDOG_CONTROL_IDX) && !pwdata[WDC_WTRF])
            begin
                watchdog_control_r[WDC_WTRF] <= 1'b0;
            end
            if (prot_wr && paddr == byte_addr(WATCHDOG_CONTROL_IDX))
            begin
                watchdog_control_r[WDC_EWT] <= pwdata[WDC_EWT];
            end
        end
    end

    // Interrupt status, write one to clear, set wins
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            irq_stat_r <= '0;
            irq_mask_r <= IRQ_MASK_RST;
        end
        else
        begin
            if (wr && paddr == byte_addr(IRQ_MASK_IDX))
            begin
                irq_mask_r <= pwdata[IRQ_W-1:0];
            end
            irq_stat_r <= (irq_stat_r &
                          ~((wr && paddr == byte_addr(IRQ_STAT_IDX)) ? pwdata[IRQ_W-1:0] : '0))
                          | {osc_evt, supply.below_warning, wd_hit};
        end
    end

    // Reset sequencer
    assign ext_rise = reset_in & ~reset_in_q_r;

    always_comb
    begin
        seq_nxt = seq_r;
        case (seq_r)
            SEQ_OFF:
            begin
                if (supply.above_reset)
                begin
                    seq_nxt = SEQ_LONG;
                end
            end
            SEQ_LONG, SEQ_SHORT:
            begin
                if (!supply.above_reset)
                begin
                    seq_nxt = SEQ_OFF;
                end
                else if (rst_cnt_r == '0)
                begin
                    seq_nxt = SEQ_RUN;
                end
            end
            default:
            begin
                if (!supply.above_reset)
                begin
                    seq_nxt = SEQ_OFF;
                end
                else if (osc_evt)
                begin
                    seq_nxt = SEQ_LONG;
                end
                else if (wd_rst_evt || ext_rise)
                begin
                    seq_nxt = SEQ_SHORT;
                end
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            seq_r        <= SEQ_OFF;
            rst_cnt_r    <= '0;
            reset_in_q_r <= 1'b0;
        end
        else
        begin
            seq_r        <= seq_nxt;
            reset_in_q_r <= reset_in;
            if (seq_nxt == SEQ_LONG && seq_r != SEQ_LONG)
            begin
                rst_cnt_r <= RC_W'(POR_CYC - 1);
            end
            else if (seq_nxt == SEQ_SHORT && seq_r == SEQ_RUN)
            begin
                // Watchdog outranks a coincident pin edge
                rst_cnt_r <= wd_rst_evt ? RC_W'(WD_RST_CYC - 1)
                                        : RC_W'(EXT_RST_CYC - 1);
            end
            else if (rst_cnt_r != '0)
            begin
                rst_cnt_r <= rst_cnt_r - RC_W'(1);
            end
        end
    end

    // Registered outputs
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            cpu_reset            <= 1'b1;
            reset_out_n          <= 1'b0;
            osc_run              <= 1'b0;
            start_addr           <= RESET_VECTOR;
            power_warning_irq    <= 1'b0;
            power_warning_vector <= 16'h0000;
            irq                  <= 1'b0;
        end
        else
        begin
            // Pin held high keeps the CPU in reset beyond the short pulse
            cpu_reset            <= (seq_nxt != SEQ_RUN) | reset_in;
            reset_out_n          <= (seq_nxt == SEQ_RUN);
            osc_run              <= (seq_nxt != SEQ_OFF);
            start_addr           <= RESET_VECTOR;
            power_warning_irq    <= watchdog_control_r[WDC_POWER_WARNING_IRQ_ENABLE] & watchdog_control_r[WDC_PFI];
            power_warning_vector <= (watchdog_control_r[WDC_POWER_WARNING_IRQ_ENABLE] & watchdog_control_r[WDC_PFI]) ?
                                    PFW_VECTOR : 16'h0000;
            irq                  <= |(irq_stat_r & irq_mask_r);
        end
    end

endmodule

`default_nettype wire

/* pkg/prs_pkg.sv */
package prs_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0]  UNLOCK_IDX    = 8'hC7;
    localparam logic [7:0]  WATCHDOG_CONTROL_IDX     = 8'hD8;
    localparam logic [7:0]  PROT_IDX      = 8'hD9;
    localparam logic [7:0]  MISC_IDX      = 8'hDA;
    localparam logic [7:0]  IRQ_STAT_IDX  = 8'hE0;
    localparam logic [7:0]  IRQ_MASK_IDX  = 8'hE1;
    localparam int          ADDR_W        = 12;

    // Unlock keys
    localparam logic [7:0]  UNLOCK_KEY1   = 8'hAA;
    localparam logic [7:0]  UNLOCK_KEY2   = 8'h55;

    // watchdog_control bit positions
    localparam int          WDC_POR       = 6;
    localparam int          WDC_POWER_WARNING_IRQ_ENABLE      = 5;
    localparam int          WDC_PFI       = 4;
    localparam int          WDC_WATCHDOG_IRQ_FLAG      = 3;
    localparam int          WDC_WTRF      = 2;
    localparam int          WDC_EWT       = 1;
    localparam int          WDC_RWT       = 0;

    // Misc control bit positions
    localparam int          MISC_OSCILLATOR_FAIL_DETECT_ENABLE     = 0;
    localparam int          MISC_OSCILLATOR_FAIL_FLAG     = 1;
    localparam int          MISC_WDSEL_LO = 4;
    localparam int          MISC_WDSEL_HI = 5;

    // Interrupt status and mask bit positions
    localparam int          IRQ_WDT       = 0;
    localparam int          IRQ_PFW       = 1;
    localparam int          IRQ_OSC       = 2;
    localparam int          IRQ_W         = 3;

    // Timing
    localparam int          CLK_PERIOD_NS     = 10;
    localparam int          MACHINE_CYC       = 4;
    localparam int          UNLOCK_WIN_MC     = 3;
    localparam int          UNLOCK_WIN_CYC    = UNLOCK_WIN_MC * MACHINE_CYC;
    localparam int          WD_RST_MC         = 2;
    localparam int          WD_RST_CYC        = WD_RST_MC * MACHINE_CYC;
    localparam int          EXT_RST_MC_X100   = 125;
    localparam int          EXT_RST_CYC       = (EXT_RST_MC_X100 * MACHINE_CYC - 1) / 100;
    localparam int          POR_CYC_DEFAULT   = 65536;

    // Vectors
    localparam logic [15:0] PFW_VECTOR    = 16'h0033;
    localparam logic [15:0] RESET_VECTOR  = 16'h0000;

    // Reset values
    localparam logic [7:0]  WATCHDOG_CONTROL_RST     = 8'h00;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

    typedef struct packed {
        logic       can_clock_out_enable;
        logic [1:0] can_clock_out_divide;
        logic       infrared_clock_out_enable;
        logic       single_bus_can;
        logic [1:0] can_unit_reset;
        logic       can_memory_map;
        logic [1:0] internal_memory_config;
        logic [1:0] address_mode_select;
        logic       stack_address_mode;
        logic       bandgap_keep_on;
    } prs_prot_cfg_t;

    typedef struct packed {
        logic above_reset;
        logic below_warning;
        logic osc_failed;
    } prs_supply_t;

    typedef enum logic [1:0] {
        SEQ_OFF   = 2'b00,
        SEQ_LONG  = 2'b01,
        SEQ_SHORT = 2'b10,
        SEQ_RUN   = 2'b11
    } prs_seq_t;

    typedef enum logic [1:0] {
        UL_IDLE   = 2'b00,
        UL_GOT1   = 2'b01,
        UL_OPEN   = 2'b10
    } prs_ul_t;

endpackage

/* tb/prs_supervisor_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
module prs_supervisor_asserts
    import prs_pkg::*;
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        srst,
    // Bus
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        pslverr,
    // Pins and outputs
    input wire prs_supply_t supply,
    input wire logic        reset_in,
    input wire logic        cpu_reset,
    input wire logic        reset_out_n,
    input wire logic        osc_run,
    input wire logic [15:0] start_addr,
    input wire logic        power_warning_irq,
    input wire logic [15:0] power_warning_vector
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    a_vector_follows: assert property (
        power_warning_vector == (power_warning_irq ? 16'h0033 : 16'h0000))
        else $error("warning vector wrong");
    a_start_zero: assert property (start_addr == 16'h0000)
        else $error("start address not zero");
    a_osc_stop: assert property (!osc_run |-> cpu_reset && !reset_out_n)
        else $error("cpu runs while oscillator restarts");
    a_supply_hold: assert property (
        !supply.above_reset |=> cpu_reset && !reset_out_n && !osc_run)
        else $error("low supply does not hold reset");
    a_pin_reset: assert property (reset_in |=> cpu_reset)
        else $error("reset pin not obeyed");
    a_low_cpu: assert property (!reset_out_n |-> cpu_reset)
        else $error("reset pin low but cpu free");
    a_ext_pulse: assert property (
        $rose(reset_in) && reset_out_n && supply == 3'b100
        |=> !reset_out_n [*4] ##1 reset_out_n)
        else $error("external reset pulse length");
    a_wd_pulse: assert property (
        $fell(reset_out_n) && !reset_in && !$past(reset_in) && supply == 3'b100
        && $past(supply) == 3'b100 |-> !reset_out_n [*8] ##1 reset_out_n)
        else $error("watchdog reset pulse length");
    a_ready_qual: assert property (pready |-> psel && penable && !$past(penable))
        else $error("pready outside access cycle");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    c_reset_fall: cover property ($fell(reset_out_n));
    c_warning: cover property (power_warning_irq);
    c_bus_error: cover property (pslverr);
endmodule
bind prs_supervisor prs_supervisor_asserts chk_u (.clk(clk), .srst(srst), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .supply(supply),
    .reset_in(reset_in), .cpu_reset(cpu_reset), .reset_out_n(reset_out_n),
    .osc_run(osc_run), .start_addr(start_addr), .power_warning_irq(power_warning_irq),
    .power_warning_vector(power_warning_vector));
`default_nettype wire

/* tb/prs_board_model.sv */
`timescale 1ns/1ns
`default_nettype none
module prs_board_model
    import prs_pkg::*;
(
    // Clock
    input wire logic  clk,
    // Requests from the bench
    input wire logic  power_ok,
    input wire logic  warn,
    input wire logic  osc_bad,
    input wire logic  pin,
    // Toward the supervisor
    output prs_supply_t supply,
    output logic      reset_in
);
    // Monitor outputs settle one clock after the bench asks
    initial
    begin
        supply = 3'b100;
        reset_in = 1'b0;
    end
    always @(posedge clk)
    begin
        supply.above_reset <= power_ok;
        supply.below_warning <= warn;
        supply.osc_failed <= osc_bad;
        reset_in <= pin;
    end
endmodule
`default_nettype wire

/* tb/protected_reset_supervisor_test.sv */
`timescale 1ns/1ns
`default_nettype none
module protected_reset_supervisor_test;
    import prs_pkg::*;
    localparam int POR = 64;
    logic              clk, srst, psel, penable, pwrite, pready, pslverr, e;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, q, d;
    prs_supply_t       supply;
    logic              reset_in, cpu_reset, reset_out_n, osc_run, power_warning_irq, irq;
    logic [15:0]       start_addr, power_warning_vector;
    prs_prot_cfg_t     prot_cfg;
    logic              power_ok, warn, osc_bad, pin;
    int                num_errors, compares, seed, n, len;

    prs_supervisor #(.POR_CYC(POR), .WD_EXP_0(4), .WD_EXP_1(5), .WD_EXP_2(6), .WD_EXP_3(7))
    dut_u (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .supply(supply), .reset_in(reset_in), .cpu_reset(cpu_reset),
        .reset_out_n(reset_out_n), .osc_run(osc_run), .start_addr(start_addr),
        .power_warning_irq(power_warning_irq), .irq(irq), .prot_cfg(prot_cfg),
        .power_warning_vector(power_warning_vector));
    prs_board_model brd_u (.clk(clk), .power_ok(power_ok), .warn(warn), .osc_bad(osc_bad),
        .pin(pin), .supply(supply), .reset_in(reset_in));

    task automatic close_out;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Waits for pready, never a fixed count
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20)
            num_errors++;
    endtask

    task automatic unlock;
        apb(1'b1, UNLOCK_IDX, 32'(UNLOCK_KEY1));
        apb(1'b1, UNLOCK_IDX, 32'(UNLOCK_KEY2));
    endtask

    task automatic pulse(input int lim, output int w, output int l);
        w = 0;
        l = 0;
        while (reset_out_n === 1'b1 && w < lim)
        begin
            @(posedge clk);
            w++;
        end
        while (reset_out_n === 1'b0 && l < 2000)
        begin
            @(posedge clk);
            l++;
        end
    endtask

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial
    begin
        #400000;
        num_errors++;
        close_out;
    end

    initial
    begin
        seed = 57;
        num_errors = 0;
        compares = 0;
        {srst, power_ok} = 2'b11;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {warn, osc_bad, pin} = 3'b000;
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        pulse(5, n, len);
        check("por_len", 32'(len >= POR && len <= POR + 3), 1);
        check("start", 32'(start_addr), 32'h0);
        apb(1'b0, WATCHDOG_CONTROL_IDX, 0);
        check("por_flag", 32'(q[WDC_POR]), 1);
        apb(1'b0, IRQ_MASK_IDX, 0);
        check("mask_rst", q, 32'(IRQ_MASK_RST));
        apb(1'b0, 8'h10, 0);
        check("unmapped", {e, q[30:0]}, 32'h80000000);
        apb(1'b1, WATCHDOG_CONTROL_IDX, 32'h02);
        apb(1'b0, WATCHDOG_CONTROL_IDX, 0);
        check("ewt_locked", 32'(q[WDC_EWT]), 0);
        unlock;
        apb(1'b1, WATCHDOG_CONTROL_IDX, 32'h00);
        apb(1'b0, WATCHDOG_CONTROL_IDX, 0);
        check("por_clear", 32'(q[WDC_POR]), 0);
        // Random protected config, then stale and reused windows
        repeat (3)
        begin
            d = $random(seed) & 32'h3FFF;
            unlock;
            apb(1'b1, PROT_IDX, d);
            apb(1'b0, PROT_IDX, 0);
            check("prot_set", q, d);
            check("prot_pins", 32'(prot_cfg), d);
            apb(1'b1, PROT_IDX, ~d);
            apb(1'b0, PROT_IDX, 0);
            check("prot_keep", q, d);
            unlock;
            apb(1'b1, MISC_IDX, 0);
            apb(1'b1, PROT_IDX, ~d);
            apb(1'b0, PROT_IDX, 0);
            check("prot_once", q, d);
        end
        // Power warning with enable, mask and sticky flag
        apb(1'b1, IRQ_MASK_IDX, 32'h2);
        apb(1'b1, WATCHDOG_CONTROL_IDX, 32'h20);
        warn <= 1'b1;
        repeat (4) @(posedge clk);
        check("pw_irq", 32'(power_warning_irq), 1);
        check("pw_vec", 32'(power_warning_vector), 32'h0033);
        check("irq_on", 32'(irq), 1);
        warn <= 1'b0;
        apb(1'b0, WATCHDOG_CONTROL_IDX, 0);
        check("pw_sticky", 32'(q[WDC_PFI]), 1);
        apb(1'b1, WATCHDOG_CONTROL_IDX, 32'h00);
        apb(1'b1, IRQ_STAT_IDX, 32'h2);
        apb(1'b1, IRQ_MASK_IDX, 32'h0);
        warn <= 1'b1;
        repeat (4) @(posedge clk);
        check("pw_off", 32'(power_warning_irq), 0);
        check("irq_masked", 32'(irq), 0);
        warn <= 1'b0;
        apb(1'b0, WATCHDOG_CONTROL_IDX, 0);
        check("pw_flag", 32'(q[WDC_PFI]), 1);
        apb(1'b1, WATCHDOG_CONTROL_IDX, 32'h00);
        apb(1'b1, IRQ_STAT_IDX, 32'h2);
        apb(1'b0, IRQ_STAT_IDX, 0);
        check("stat_clr", 32'(q[IRQ_PFW]), 0);
        // Watchdog serviced, then starved
        apb(1'b1, MISC_IDX, 32'h10);
        repeat (5)
        begin
            unlock;
            apb(1'b1, WATCHDOG_CONTROL_IDX, 32'h03);
        end
        check("wd_fed", 32'(reset_out_n), 1);
        pulse(80, n, len);
        check("wd_fire", 32'(n < 70), 1);
        check("wd_len", 32'(len), 32'(WD_RST_CYC));
        apb(1'b0, WATCHDOG_CONTROL_IDX, 0);
        check("wd_flags", 32'(q[WDC_WTRF] & q[WDC_WATCHDOG_IRQ_FLAG]), 1);
        unlock;
        apb(1'b1, WATCHDOG_CONTROL_IDX, 32'h00);
        // External reset pin
        pin <= 1'b1;
        @(posedge clk);
        pin <= 1'b0;
        pulse(10, n, len);
        check("ext_len", 32'(len), 32'(EXT_RST_CYC));
        // Supply loss and recovery
        power_ok <= 1'b0;
        repeat (20) @(posedge clk);
        check("hold_cpu", 32'(cpu_reset), 1);
        check("osc_stop", 32'(osc_run), 0);
        power_ok <= 1'b1;
        pulse(2, n, len);
        check("pf_len", 32'(len >= POR && len <= POR + 3), 1);
        // Oscillator failure with detection on
        unlock;
        apb(1'b1, MISC_IDX, 32'h31);
        osc_bad <= 1'b1;
        @(posedge clk);
        osc_bad <= 1'b0;
        pulse(10, n, len);
        check("of_len", 32'(len >= POR && len <= POR + 3), 1);
        apb(1'b0, MISC_IDX, 0);
        check("of_flag", 32'(q[MISC_OSCILLATOR_FAIL_FLAG]), 1);
        close_out;
    end
endmodule
`default_nettype wire
